// *** rtl/dac_front.sv ***
// Purpose: reset/init, clock output, audio input port, control port, APB
// Assumes: all pins pass the synchroniser before use
// Notes: control port and audio port share only the mode registers
`timescale 1ns/10ps
module dac_front
    import dac_front_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic core_supply_ok_i,
    input wire logic external_reset_n_i,
    input wire logic audio_bit_clock_i,
    input wire logic word_select_clock_i,
    input wire logic audio_data_i,
    input wire logic ctrl_shift_clock_i,
    input wire logic ctrl_latch_i,
    input wire logic ctrl_data_in_i,
    input wire apb_req_t apb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    output logic ctrl_data_out_o,
    output logic ctrl_data_out_oe_o,
    output logic buffered_clock_out_o,
    output logic init_busy_o,
    output logic [23:0] left_sample_o,
    output logic [23:0] right_sample_o
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] mode_byte(input logic [47:0] m,
                                             input logic [6:0] idx);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < MODE_REGS; i++)
            if (idx == 7'(MODE_FIRST + 7'(i)))
                r = m[i*8 +: 8];
        return r;
    endfunction : mode_byte

    // standard framing: right-justified word, widened msb-aligned
    function automatic logic [23:0] std_align(input audio_fmt_t f,
                                              input logic [23:0] s);
        logic [23:0] r;
        case (f)
            FMT_STD20: r = {s[19:0], 4'h0};
            FMT_STD18: r = {s[17:0], 6'h00};
            FMT_STD16: r = {s[15:0], 8'h00};
            default: r = s;
        endcase
        return r;
    endfunction : std_align

    core_state_t st;
    core_state_t next_st;
    pins_t pin;
    pins_t raw;

    logic restart;
    logic bit_rise;
    logic word_edge;
    logic shift_rise;
    logic shift_fall;
    logic latch_rise;
    logic latch_fall;
    logic [7:0] mode20;
    logic [6:0] rd_idx;
    logic [7:0] rd_pick;
    audio_fmt_t fmt;
    logic is_std;
    logic apb_setup;
    logic apb_write;
    logic [6:0] wr_idx;

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    assign raw = '{supply_ok: core_supply_ok_i,
                   ext_reset_n: external_reset_n_i,
                   bit_clk: audio_bit_clock_i,
                   word_sel: word_select_clock_i,
                   audio_data: audio_data_i,
                   shift_clk: ctrl_shift_clock_i,
                   latch: ctrl_latch_i,
                   din: ctrl_data_in_i};

    pin_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .d_i(raw),
        .q_o(pin)
    );

    assign restart = ~pin.supply_ok | ~pin.ext_reset_n;
    assign bit_rise = pin.bit_clk & ~st.bit_clk_d;
    assign word_edge = pin.word_sel ^ st.word_sel_d;
    assign shift_rise = pin.shift_clk & ~st.shift_clk_d;
    assign shift_fall = ~pin.shift_clk & st.shift_clk_d;
    assign latch_rise = pin.latch & ~st.latch_d;
    assign latch_fall = ~pin.latch & st.latch_d;

    assign mode20 = st.mode[R20_POS +: 8];
    assign rd_idx = st.mode[R21_POS +: 7];
    assign rd_pick = mode_byte(st.mode, rd_idx);
    assign fmt = audio_fmt_t'(mode20[2:0]);
    assign is_std = (fmt != FMT_I2S) && (fmt != FMT_LJ);
    assign apb_setup = apb_i.psel & ~apb_i.penable & ~st.pready;
    assign apb_write = apb_i.psel & apb_i.penable & st.pready &
                       apb_i.pwrite & ~st.pslverr & ~st.init_busy;
    assign wr_idx = st.cmd[14:8];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.bit_clk_d = pin.bit_clk;
        next_st.word_sel_d = pin.word_sel;
        next_st.shift_clk_d = pin.shift_clk;
        next_st.latch_d = pin.latch;

        // audio input port
        if (bit_rise)
        begin
            next_st.shift_a = {st.shift_a[22:0], pin.audio_data};
            if (st.bit_cnt != 6'h3f)
                next_st.bit_cnt = 6'(st.bit_cnt + 6'h01);
            if ((fmt == FMT_LJ && next_st.bit_cnt == LJ_LEN) ||
                (fmt == FMT_I2S && next_st.bit_cnt == I2S_LEN))
            begin
                next_st.pend = next_st.shift_a;
                next_st.pend_left = (fmt == FMT_I2S) ?
                                    ~pin.word_sel : pin.word_sel;
                next_st.pend_ok = 1'b1;
            end
        end
        if (word_edge)
        begin
            next_st.bit_cnt = 6'h00;
            if (is_std)
            begin
                // word just ended belongs to the old word-select level
                if (st.word_sel_d)
                    next_st.left = std_align(fmt, st.shift_a);
                else
                    next_st.right = std_align(fmt, st.shift_a);
            end
            else if (st.pend_ok)
            begin
                if (st.pend_left)
                    next_st.left = st.pend;
                else
                    next_st.right = st.pend;
                next_st.pend_ok = 1'b0;
            end
        end

        // apb slave: answer prepared in setup, taken in access
        if (apb_setup)
        begin
            next_st.pready = 1'b1;
            next_st.pslverr = 1'b0;
            case (apb_i.paddr)
                A_STATUS: next_st.prdata = {30'h0, st.reading,
                                            st.init_busy};
                A_MODE20: next_st.prdata = {24'h0, mode20};
                A_MODE21: next_st.prdata = {24'h0, st.mode[R21_POS +: 8]};
                A_LEFT: next_st.prdata = {8'h00, st.left};
                A_RIGHT: next_st.prdata = {8'h00, st.right};
                default:
                begin
                    next_st.prdata = 32'h0;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        else if (apb_i.psel & apb_i.penable & st.pready)
        begin
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
        end
        if (apb_write && apb_i.paddr == A_MODE20)
            next_st.mode[R20_POS +: 8] = apb_i.pwdata[7:0];
        if (apb_write && apb_i.paddr == A_MODE21)
            next_st.mode[R21_POS +: 8] = apb_i.pwdata[7:0];

        // control port, independent of the audio clocks
        if (latch_fall | latch_rise)
        begin
            next_st.cmd_cnt = 5'h00;
            next_st.reading = 1'b0;
            next_st.dout_oe = 1'b0;
        end
        if (latch_rise && st.cmd_cnt == CMD_LEN && !st.cmd[CMD_RNW])
        begin
            for (int i = 0; i < MODE_REGS; i++)
                if (wr_idx == 7'(MODE_FIRST + 7'(i)))
                    next_st.mode[i*8 +: 8] = st.cmd[7:0];
        end
        if (shift_rise && !pin.latch && st.cmd_cnt < CMD_LEN)
        begin
            next_st.cmd = {st.cmd[14:0], pin.din};
            next_st.cmd_cnt = 5'(st.cmd_cnt + 5'h01);
            if (next_st.cmd_cnt == CMD_HALF && next_st.cmd[HALF_RNW])
            begin
                next_st.reading = 1'b1;
                next_st.rd_byte = rd_pick;
            end
        end
        if (shift_fall && !pin.latch && st.reading &&
            st.cmd_cnt >= CMD_HALF && st.cmd_cnt < CMD_LEN)
        begin
            next_st.dout = st.rd_byte[7];
            next_st.rd_byte = {st.rd_byte[6:0], 1'b0};
            next_st.dout_oe = 1'b1;
        end

        // init sequence owns the mode registers while it runs
        if (restart)
        begin
            next_st.init_busy = 1'b1;
            next_st.init_cnt = 11'h000;
        end
        else if (st.init_busy)
        begin
            next_st.init_cnt = 11'(st.init_cnt + 11'h001);
            if (st.init_cnt == INIT_LAST)
                next_st.init_busy = 1'b0;
        end
        if (restart | st.init_busy)
        begin
            next_st.mode = MODE_DEFAULTS;
            next_st.reading = 1'b0;
            next_st.dout_oe = 1'b0;
            next_st.cmd_cnt = 5'h00;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            st <= '0;
            st.init_busy <= 1'b1;
            st.mode <= MODE_DEFAULTS;
            st.latch_d <= 1'b1;
        end
        else
            st <= next_st;
    end

    // ------------------------------------------------------------
    // clock output and ports
    // ------------------------------------------------------------
    clock_out_drv u_clk_out (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .enable_i(mode20[CLOCK_OUT_ENABLE_BIT_BIT]),
        .halve_i(mode20[CLOCK_OUT_HALVE_SEL_BIT]),
        .buffered_clock_out_o(buffered_clock_out_o)
    );

    assign pready_o = st.pready;
    assign prdata_o = st.prdata;
    assign pslverr_o = st.pslverr;
    assign ctrl_data_out_o = st.dout;
    assign ctrl_data_out_oe_o = st.dout_oe;
    assign init_busy_o = st.init_busy;
    assign left_sample_o = st.left;
    assign right_sample_o = st.right;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [11:0] init_run;
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || restart)
            init_run <= 12'h000;
        else if (st.init_busy)
            init_run <= 12'(init_run + 12'h001);
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    init_len_a: assert property ($fell(st.init_busy) |->
        init_run == 12'(INIT_CYCLES))
        else $error("init did not last 1024 cycles");
    init_defaults_a: assert property ($fell(st.init_busy) |->
        st.mode == MODE_DEFAULTS && st.mode[R21_POS +: 8] == 8'h01)
        else $error("mode settings not at defaults after init");
    restart_busy_a: assert property (restart |=>
        st.init_busy && st.init_cnt == 11'h000)
        else $error("reset release did not restart init");
    audio_shift_a: assert property (bit_rise |=>
        st.shift_a[0] == $past(pin.audio_data))
        else $error("audio bit not shifted on bit clock rise");
    word_xfer_a: assert property ($changed(st.left) |->
        $past(word_edge))
        else $error("left sample changed without word edge");
    std_fmt_a: assert property (word_edge && fmt == FMT_STD24 &&
        st.word_sel_d |=> st.left == $past(st.shift_a))
        else $error("standard 24-bit sample wrongly captured");
    ctrl_write_a: assert property (latch_rise && !st.init_busy &&
        !restart && st.cmd_cnt == CMD_LEN && !st.cmd[CMD_RNW] &&
        wr_idx == MODE_FMT_IDX |=> mode20 == $past(st.cmd[7:0]))
        else $error("command write not stored on latch rise");
    read_src_a: assert property ($rose(st.reading) |->
        st.rd_byte == $past(rd_pick))
        else $error("readback not from readback index");
    oe_window_a: assert property (st.dout_oe |->
        st.reading && st.cmd_cnt >= CMD_HALF && !st.latch_d)
        else $error("read output driven outside data phase");
    read_quiet_a: assert property (st.reading && !apb_write &&
        !restart |=> $stable(st.mode))
        else $error("mode register changed during read");
    apb_ready_a: assert property (apb_setup |=> st.pready ##1 !st.pready)
        else $error("apb answer not one cycle after setup");
endmodule : dac_front

// *** rtl/dac_front_pkg.sv ***
// Purpose: shared constants and types of the audio converter front end
// Assumes: one 20 MHz master clock, APB register access
// Notes: mode registers 16..21 are held as six bytes, index 16 lowest
package dac_front_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int EXT_RST_MIN_NS = 20;
    localparam int EXT_RST_MIN_CYC =
        (EXT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CYCLES = 1024;
    localparam logic [10:0] INIT_LAST = 11'(INIT_CYCLES - 1);

    // ----------------------------------------------------------------
    // mode registers
    // ----------------------------------------------------------------
    localparam int MODE_REGS = 6;
    localparam logic [6:0] MODE_FIRST = 7'h10;
    localparam logic [6:0] MODE_FMT_IDX = 7'h14;
    localparam int R20_POS = 32;
    localparam int R21_POS = 40;
    localparam int CLOCK_OUT_HALVE_SEL_BIT = 4;
    localparam int CLOCK_OUT_ENABLE_BIT_BIT = 3;
    localparam int INC_BIT = 7;
    localparam logic [7:0] DEF_ATT = 8'h00;
    localparam logic [7:0] DEF_R18 = 8'h00;
    localparam logic [7:0] DEF_R19 = 8'h00;
    localparam logic [7:0] DEF_R20 = 8'h08;
    localparam logic [7:0] DEF_R21 = 8'h01;
    localparam logic [47:0] MODE_DEFAULTS =
        {DEF_R21, DEF_R20, DEF_R19, DEF_R18, DEF_ATT, DEF_ATT};

    // ----------------------------------------------------------------
    // control command word
    // ----------------------------------------------------------------
    localparam logic [4:0] CMD_LEN = 5'h10;
    localparam logic [4:0] CMD_HALF = 5'h08;
    localparam int CMD_RNW = 15;
    localparam int HALF_RNW = 7;

    // ----------------------------------------------------------------
    // audio framing
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FMT_STD24 = 3'b000,
        FMT_STD20 = 3'b001,
        FMT_STD18 = 3'b010,
        FMT_STD16 = 3'b011,
        FMT_I2S = 3'b100,
        FMT_LJ = 3'b101
    } audio_fmt_t;
    localparam logic [5:0] LJ_LEN = 6'h18;
    localparam logic [5:0] I2S_LEN = 6'h19;

    // ----------------------------------------------------------------
    // apb map
    // ----------------------------------------------------------------
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_MODE20 = 8'h04;
    localparam logic [7:0] A_MODE21 = 8'h08;
    localparam logic [7:0] A_LEFT = 8'h0c;
    localparam logic [7:0] A_RIGHT = 8'h10;

    // ----------------------------------------------------------------
    // carriers and state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic supply_ok;
        logic ext_reset_n;
        logic bit_clk;
        logic word_sel;
        logic audio_data;
        logic shift_clk;
        logic latch;
        logic din;
    } pins_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        pins_t meta;
        pins_t q;
    } sync_state_t;

    typedef struct packed {
        logic en;
        logic halve;
        logic div;
    } clk_out_state_t;

    typedef struct packed {
        logic init_busy;
        logic [10:0] init_cnt;
        logic [47:0] mode;
        logic bit_clk_d;
        logic word_sel_d;
        logic shift_clk_d;
        logic latch_d;
        logic [23:0] shift_a;
        logic [5:0] bit_cnt;
        logic [23:0] pend;
        logic pend_left;
        logic pend_ok;
        logic [23:0] left;
        logic [23:0] right;
        logic [15:0] cmd;
        logic [4:0] cmd_cnt;
        logic reading;
        logic [7:0] rd_byte;
        logic dout;
        logic dout_oe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } core_state_t;

endpackage : dac_front_pkg

// *** rtl/pin_sync.sv ***
// Purpose: two-flop synchroniser for all pin inputs
// Assumes: pins are asynchronous to the master clock
// Notes: only q_o may be read by other logic
`timescale 1ns/10ps
module pin_sync
    import dac_front_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire pins_t d_i,
    output pins_t q_o
);
    sync_state_t st;
    sync_state_t next_st;

    always_comb
    begin
        next_st.meta = d_i;
        next_st.q = st.meta;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            st <= '0;
            // latch idles high: no false latch edge after reset
            st.meta.latch <= 1'b1;
            st.q.latch <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign q_o = st.q;
endmodule : pin_sync

// *** rtl/clock_out_drv.sv ***
// Purpose: buffered master clock output, full or half rate, gated
// Assumes: enable and halve come from mode register 20
// Notes: full rate passes the master clock through the registered gate
`timescale 1ns/10ps
module clock_out_drv
    import dac_front_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic enable_i,
    input wire logic halve_i,
    output logic buffered_clock_out_o
);
    clk_out_state_t st;
    clk_out_state_t next_st;

    always_comb
    begin
        next_st.en = enable_i;
        next_st.halve = halve_i;
        next_st.div = ~st.div;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            st <= '0;
            st.en <= DEF_R20[CLOCK_OUT_ENABLE_BIT_BIT];
        end
        else
            st <= next_st;
    end

    // rate select and gate; a setting change may give one short pulse
    assign buffered_clock_out_o =
        st.en & (st.halve ? st.div : ref_clk_i);

    clk_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !$past(enable_i) |-> !buffered_clock_out_o)
        else $error("clock output active while disabled");
endmodule : clock_out_drv

// *** tb/ctrl_host_model.sv ***
// Purpose: host side of the four-wire control port
// Assumes: device samples the pins through a two-flop synchroniser
// Notes: each shift clock phase lasts six master clocks
`timescale 1ns/10ps
module ctrl_host_model
(
    input wire logic ref_clk_i,
    input wire logic dout_i,
    input wire logic oe_i,
    output logic latch_o,
    output logic sclk_o,
    output logic din_o
);
    initial
    begin
        latch_o = 1'b1;
        sclk_o = 1'b0;
        din_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : wait_clk

    // rd collects readback bits, oe the enable seen before each rise
    task automatic xfer(input logic [15:0] w, output logic [7:0] rd,
                        output logic [15:0] oe);
        rd = 8'h00;
        oe = 16'h0000;
        latch_o <= 1'b0;
        wait_clk(6);
        for (int i = 15; i >= 0; i--)
        begin
            din_o <= w[i];
            wait_clk(6);
            oe[i] = oe_i;
            if (i < 8)
                rd[i] = dout_i;
            sclk_o <= 1'b1;
            wait_clk(6);
            sclk_o <= 1'b0;
        end
        wait_clk(6);
        latch_o <= 1'b1;
        din_o <= ~w[0];
        wait_clk(8);
    endtask : xfer
endmodule : ctrl_host_model

// *** tb/audio_dac_ctrl_and_serial_ports_tb_top.sv ***
// Purpose: self-checking bench of the converter front end
// Assumes: apb answers with pready; audio source gives 64 bits a frame
// Notes: mode register contents mirrored in m20 and m21
`timescale 1ns/10ps
module audio_dac_ctrl_and_serial_ports_tb_top
    import dac_front_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ext_rst_n = 1'b1;
    logic supply_ok = 1'b1;
    apb_req_t apb = '0;
    logic latch, sclk, din, pready, pslverr, dout, oe, clk_out, busy, err;
    logic [31:0] prdata, got;
    logic [23:0] left_s, right_s;
    logic [7:0] rd, v;
    logic [15:0] oe_v;
    int n_mismatch = 0;
    int total_checks = 0;
    int m20, m21, cnt;
    logic bclk = 1'b0;
    logic wsel = 1'b0;
    logic adata = 1'b0;
    logic [23:0] smp_l, smp_r;
    logic [2:0] f;
    int off;
    int n_buffered_clock_out = 0;

    dac_front dac_front_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .core_supply_ok_i(supply_ok), .external_reset_n_i(ext_rst_n),
        .audio_bit_clock_i(bclk), .word_select_clock_i(wsel),
        .audio_data_i(adata), .ctrl_shift_clock_i(sclk),
        .ctrl_latch_i(latch), .ctrl_data_in_i(din), .apb_i(apb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .ctrl_data_out_o(dout), .ctrl_data_out_oe_o(oe),
        .buffered_clock_out_o(clk_out), .init_busy_o(busy),
        .left_sample_o(left_s), .right_sample_o(right_s));

    ctrl_host_model ctrl_host_model_inst (.ref_clk_i(ref_clk_i),
        .dout_i(dout), .oe_i(oe), .latch_o(latch), .sclk_o(sclk),
        .din_o(din));

    always @(posedge clk_out)
        n_buffered_clock_out++;

    initial
    begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] wd);
        @(posedge ref_clk_i);
        apb <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge ref_clk_i);
        apb.penable <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
        end
        while (pready !== 1'b1);
        got = prdata;
        err = pslverr;
        apb <= '0;
    endtask : apb_xfer

    // ----------------------------------------------------------------
    // audio source: 64 bit clocks a frame, 128 master clocks a sample
    // ----------------------------------------------------------------
    task automatic audio_word(input logic ws, input logic [23:0] s,
                              input int o);
        for (int j = 0; j < 32; j++)
        begin
            wsel <= ws;
            bclk <= 1'b0;
            adata <= (j >= o && j < o + 24) ? s[23 - j + o] : 1'b0;
            repeat (2) @(posedge ref_clk_i);
            bclk <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
        end
    endtask : audio_word

    // left word first; the leading four clocks at the other level force a word edge
    task automatic audio_frame(input int o, input logic [23:0] l,
                               input logic [23:0] r);
        logic ws_l;
        ws_l = (o != 1); // i2s puts left on the low level
        wsel <= ~ws_l;
        bclk <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        audio_word(ws_l, l, o);
        audio_word(~ws_l, r, o);
        wsel <= ws_l;
        bclk <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
    endtask : audio_frame

    // clock output rises counted over 16 master clocks
    task automatic clk_out_chk(input logic [7:0] m);
        int n0;
        logic [31:0] e;
        e = m[3] ? (m[4] ? 32'h8 : 32'h10) : 32'h0;
        @(negedge ref_clk_i);
        n0 = n_buffered_clock_out;
        repeat (16) @(negedge ref_clk_i);
        chk(32'(n_buffered_clock_out - n0), e);
        @(posedge ref_clk_i);
    endtask : clk_out_chk

    // ----------------------------------------------------------------
    // reset defaults of mode registers 20 and 21
    // ----------------------------------------------------------------
    task automatic check_defaults();
        m20 = 8'h08;
        m21 = 8'h01;
        apb_xfer(1'b0, A_MODE20, 32'h0);
        chk(got, 32'(m20));
        apb_xfer(1'b0, A_MODE21, 32'h0);
        chk(got, 32'(m21));
    endtask : check_defaults

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        test_done();
    end

    initial
    begin
        void'($urandom(8));
        repeat (12) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        for (int r = 0; r < 3; r++)
        begin
            if (r == 1)
                ext_rst_n <= 1'b0;
            if (r == 2)
                supply_ok <= 1'b0;
            repeat ((r == 0) ? 0 : 4) @(posedge ref_clk_i);
            ext_rst_n <= 1'b1;
            supply_ok <= 1'b1;
            cnt = 0;
            do
            begin
                @(posedge ref_clk_i);
                cnt++;
            end
            while (busy !== 1'b0 && cnt < 1200);
            chk(32'(cnt >= 1024 && cnt <= 1034), 32'h1);
            check_defaults();
            clk_out_chk(8'(m20));
            f = (r == 0) ? 3'b000 : ((r == 1) ? 3'b101 : 3'b100);
            off = (r == 0) ? 8 : ((r == 1) ? 0 : 1);
            m20 = 8'h08 | f;
            apb_xfer(1'b1, A_MODE20, 32'(m20));
            smp_l = 24'($urandom());
            smp_r = 24'($urandom());
            audio_frame(off, smp_l, smp_r);
            chk(32'(left_s), 32'(smp_l));
            chk(32'(right_s), 32'(smp_r));
            v = 8'($urandom());
            m20 = v;
            ctrl_host_model_inst.xfer({1'b0, MODE_FMT_IDX, v}, rd, oe_v);
            apb_xfer(1'b0, A_MODE20, 32'h0);
            chk(got, 32'(m20));
            clk_out_chk(v);
            m21 = 8'h14;
            apb_xfer(1'b1, A_MODE21, 32'(m21));
            for (int i = 0; i < 2; i++)
            begin
                ctrl_host_model_inst.xfer({1'b1, i ? 7'h15 : 7'h00, 8'h5a},
                                          rd, oe_v);
                chk(32'(rd), 32'(m20));
                chk(32'(oe_v), 32'h00ff);
            end
            ctrl_host_model_inst.xfer({1'b0, 7'h05, ~v}, rd, oe_v);
            m21 = 8'h15;
            ctrl_host_model_inst.xfer({1'b0, 7'h15, 8'h15}, rd, oe_v);
            ctrl_host_model_inst.xfer({1'b1, 7'h00, ~v}, rd, oe_v);
            chk(32'(rd), 32'(m21));
            apb_xfer(1'b0, A_MODE20, 32'h0);
            chk(got, 32'(m20));
            apb_xfer(1'b0, 8'h20, 32'h0);
            chk({got[30:0], err}, 32'h1);
        end
        test_done();
    end
endmodule : audio_dac_ctrl_and_serial_ports_tb_top
